/* File: serial_node_model.sv */
// Remote serial node model: feeds received frames in and decodes the transmit line
`timescale 1ns/1ps

module serial_node_model #(
    parameter int BIT_CYCLES = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Line from the slice and the framing it expects
    input wire logic tx_out,
    input wire logic nine_mode,
    // Frames handed to the slice
    output logic rx_frame_done,
    output serial_pkg::rx_frame_t rx_frame
);
    logic [9:0] got_q[$];
    logic [8:0] bits;
    logic stop_bit;

    // Idle outputs at time zero
    initial
    begin
        rx_frame_done = 1'b0;
        rx_frame = '0;
    end

    // One-cycle pulse; the bus is inverted afterwards so stale data never looks valid
    task automatic send(input logic [8:0] d, input logic nz, input logic sb, input logic pb);
        @(posedge core_clk);
        rx_frame_done <= 1'b1;
        rx_frame <= {d, nz, sb, pb};
        @(posedge core_clk);
        rx_frame_done <= 1'b0;
        rx_frame <= ~{d, nz, sb, pb};
    endtask

    // Mid-bit sampler, LSB first, on the falling edge so it never races the line's launch
    initial
    begin
        forever
        begin
            @(negedge core_clk);
            if (nrst === 1'b1 && tx_out === 1'b0)
            begin
                repeat (BIT_CYCLES / 2) @(negedge core_clk);
                bits = '0;
                for (int i = 0; i < (nine_mode ? 9 : 8); i++)
                begin
                    repeat (BIT_CYCLES) @(negedge core_clk);
                    bits[i] = tx_out;
                end
                repeat (BIT_CYCLES) @(negedge core_clk);
                stop_bit = tx_out;
                got_q.push_back({stop_bit, bits});
            end
        end
    end
endmodule // serial_node_model

/* File: serial_pkg.sv */
// Shared constants and carrier types of the asynchronous serial slice
package serial_pkg;

    // Register byte addresses on the APB
    localparam logic [11:0] STATUS_ONE_ADDR = 12'h000;
    localparam logic [11:0] DATA_HIGH_ADDR = 12'h004;
    localparam logic [11:0] DATA_LOW_ADDR = 12'h008;
    localparam logic [11:0] CONTROL_ONE_ADDR = 12'h00c;

    // Status one bit positions
    localparam int PARITY_ERR_BIT = 0;
    localparam int FRAMING_ERR_BIT = 1;
    localparam int NOISE_BIT = 2;
    localparam int OVERRUN_BIT = 3;
    localparam int RX_FULL_BIT = 5;
    localparam int TX_IDLE_BIT = 7;

    // Control one bit positions
    localparam int PARITY_TYPE_BIT = 0;
    localparam int PARITY_ENABLE_BIT = 1;
    localparam int TX_ENABLE_BIT = 2;
    localparam int NINE_BIT_BIT = 4;

    // Data high bit positions
    localparam int NINTH_TX_POS = 6;
    localparam int NINTH_RX_POS = 7;

    // Reset values
    localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
    localparam logic [3:0] ERR_FLAGS_RESET = 4'h0;

    // Frame lengths on the line: start, data, stop
    localparam logic [3:0] FRAME_BITS_EIGHT = 4'ha;
    localparam logic [3:0] FRAME_BITS_NINE = 4'hb;

    // Default bit time
    localparam int BIT_TIME_NS = 8680;
    localparam int CLK_PERIOD_NS = 8;
    localparam int BIT_CYCLES_DEFAULT = BIT_TIME_NS / CLK_PERIOD_NS;

    // Character bound for the transmit buffer
    typedef struct packed {
        logic ninth;
        logic [7:0] low;
    } tx_word_t;

    // Frame handed over by the receive sampler
    typedef struct packed {
        logic [8:0] data;
        logic noise;
        logic stop_bit;
        logic parity_bit;
    } rx_frame_t;

    // Transmitter states
    typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;

endpackage

/* File: serial_rx_errors_tx.sv */
// Receive error flags, register slave and transmit path of the serial slice
`timescale 1ns/1ps

module tx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0] count_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Honest full and empty from the fill count
    assign in_ready = (count_q != (PTR_W+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign out_data = mem[rd_ptr_q];

    // Storage carries no reset; only the pointers and the fill count need a defined state
    always_ff @(posedge core_clk)
    begin
        if (push)
            mem[wr_ptr_q] <= in_data;
    end

    // Pointers wrap by power-of-two depth
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= rd_ptr_q + 1'b1;
            count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

    a_fifo_no_overfill: assert property (@(posedge core_clk) disable iff (!nrst)
        count_q == (PTR_W+1)'(DEPTH) |-> !push)
        else $error("fifo accepted a word while full");
endmodule // tx_fifo

module serial_rx_errors_tx #(
    parameter int BIT_CYCLES = serial_pkg::BIT_CYCLES_DEFAULT,
    parameter int FIFO_DEPTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Frames from the receive sampler
    input wire logic rx_frame_done,
    input wire serial_pkg::rx_frame_t rx_frame,
    output logic rx_accept_ok,
    // Serial line
    output logic tx_out
);
    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);

    // Register state
    logic [7:0] control_q;
    logic ninth_tx_bit_q;
    logic [8:0] rx_data_q;
    logic receive_full_flag_q;
    logic [3:0] err_q;
    logic [3:0] armed_q;

    // Transmit state
    serial_pkg::tx_state_t tx_state_q;
    logic [10:0] shift_q;
    logic [3:0] bits_left_q;
    logic [15:0] baud_cnt_q;
    logic tx_out_q;

    // Bus decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    wire sel_status = hit(paddr, serial_pkg::STATUS_ONE_ADDR);
    wire sel_high = hit(paddr, serial_pkg::DATA_HIGH_ADDR);
    wire sel_low = hit(paddr, serial_pkg::DATA_LOW_ADDR);
    wire sel_ctrl = hit(paddr, serial_pkg::CONTROL_ONE_ADDR);
    wire mapped = sel_status || sel_high || sel_low || sel_ctrl;

    // A low data write stalls the bus while the buffer is full
    logic fifo_in_ready;
    wire low_write_req = psel && penable && pwrite && sel_low;
    assign pready = !low_write_req || fifo_in_ready;
    assign pslverr = psel && penable && !mapped;
    wire acc = psel && penable && pready;
    wire status_read = acc && !pwrite && sel_status;
    wire low_read = acc && !pwrite && sel_low;
    wire low_write = acc && pwrite && sel_low;
    wire high_write = acc && pwrite && sel_high;
    wire ctrl_write = acc && pwrite && sel_ctrl;

    // Control decode
    wire parity_type = control_q[serial_pkg::PARITY_TYPE_BIT];
    wire parity_enable = control_q[serial_pkg::PARITY_ENABLE_BIT];
    wire tx_enable = control_q[serial_pkg::TX_ENABLE_BIT];
    wire nine_bit = control_q[serial_pkg::NINE_BIT_BIT];

    // Frame classification on arrival
    wire framing_error_flag = err_q[serial_pkg::FRAMING_ERR_BIT];
    assign rx_accept_ok = !framing_error_flag;
    wire frame_in = rx_frame_done && !framing_error_flag;
    wire overrun_evt = frame_in && receive_full_flag_q;
    wire take_frame = frame_in && !receive_full_flag_q;
    wire [8:0] rx_bits = nine_bit ? rx_frame.data : {1'b0, rx_frame.data[7:0]};
    wire parity_bad = parity_enable && ((^rx_bits ^ rx_frame.parity_bit) != parity_type);
    logic [3:0] err_set;
    always_comb
    begin
        err_set = '0;
        err_set[serial_pkg::OVERRUN_BIT] = overrun_evt;
        err_set[serial_pkg::NOISE_BIT] = take_frame && rx_frame.noise;
        err_set[serial_pkg::FRAMING_ERR_BIT] = take_frame && !rx_frame.stop_bit;
        err_set[serial_pkg::PARITY_ERR_BIT] = take_frame && parity_bad;
    end

    // Only flags armed by an earlier status read are cleared
    wire [3:0] err_clr = low_read ? armed_q : 4'h0;

    // Error flags and their arming; a set in the clear cycle wins
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            err_q <= serial_pkg::ERR_FLAGS_RESET;
            armed_q <= serial_pkg::ERR_FLAGS_RESET;
        end
        else
        begin
            err_q <= (err_q & ~err_clr) | err_set;
            if (status_read)
                armed_q <= err_q;
            else if (low_read)
                armed_q <= '0;
        end
    end

    // Receive data and full flag; overrun leaves the held character alone
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rx_data_q <= '0;
            receive_full_flag_q <= 1'b0;
        end
        else
        begin
            if (take_frame)
                rx_data_q <= rx_bits;
            if (take_frame)
                receive_full_flag_q <= 1'b1;
            else if (low_read)
                receive_full_flag_q <= 1'b0;
        end
    end

    // Control and ninth transmit bit
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            control_q <= serial_pkg::CONTROL_ONE_RESET;
            ninth_tx_bit_q <= 1'b0;
        end
        else
        begin
            if (ctrl_write)
                control_q <= pwdata[7:0];
            if (high_write)
                ninth_tx_bit_q <= pwdata[serial_pkg::NINTH_TX_POS];
        end
    end

    // Transmit buffer; data registers are write-only toward the shifter
    serial_pkg::tx_word_t fifo_out;
    logic fifo_out_valid;
    wire tx_load = tx_enable && (tx_state_q == serial_pkg::TX_IDLE) && fifo_out_valid;
    tx_fifo #(.WIDTH($bits(serial_pkg::tx_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .in_valid(low_write_req),
        .in_ready(fifo_in_ready),
        .in_data({ninth_tx_bit_q, pwdata[7:0]}),
        .out_valid(fifo_out_valid),
        .out_ready(tx_load),
        .out_data(fifo_out)
    );

    // Read mux; every source but the tx_idle bit is a flop, data reads return the received character, not what was written
    wire tx_idle = (tx_state_q == serial_pkg::TX_IDLE) && !fifo_out_valid;
    logic [7:0] status_view;
    always_comb
    begin
        status_view = {4'h0, err_q};
        status_view[serial_pkg::RX_FULL_BIT] = receive_full_flag_q;
        status_view[serial_pkg::TX_IDLE_BIT] = tx_idle;
    end
    wire [7:0] high_view = 8'(rx_data_q[8]) << serial_pkg::NINTH_RX_POS;
    assign prdata = !(psel && !pwrite) ? 32'h0000_0000 :
        sel_status ? {24'h00_0000, status_view} :
        sel_high ? {24'h00_0000, high_view} :
        sel_low ? {24'h00_0000, rx_data_q[7:0]} :
        sel_ctrl ? {24'h00_0000, control_q} : 32'h0000_0000;

    // Bit-time enable; restarted at each load so the start bit is whole
    wire bit_tick = (baud_cnt_q == BIT_LAST);
    wire [10:0] frame_word = nine_bit ? {1'b1, fifo_out.ninth, fifo_out.low, 1'b0}
                                      : {2'b11, fifo_out.low, 1'b0};

    // Shifter: start low, data LSB first, stop high
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_state_q <= serial_pkg::TX_IDLE;
            shift_q <= '1;
            bits_left_q <= '0;
            baud_cnt_q <= '0;
            tx_out_q <= 1'b1;
        end
        else
        begin
            case (tx_state_q)
                serial_pkg::TX_IDLE:
                begin
                    tx_out_q <= 1'b1;
                    if (tx_load)
                    begin
                        shift_q <= frame_word >> 1;
                        tx_out_q <= frame_word[0];
                        bits_left_q <= nine_bit ? serial_pkg::FRAME_BITS_NINE
                                                : serial_pkg::FRAME_BITS_EIGHT;
                        baud_cnt_q <= '0;
                        tx_state_q <= serial_pkg::TX_SHIFT;
                    end
                end
                serial_pkg::TX_SHIFT:
                begin
                    baud_cnt_q <= bit_tick ? 16'h0000 : baud_cnt_q + 16'h0001;
                    if (bit_tick)
                    begin
                        bits_left_q <= bits_left_q - 4'h1;
                        if (bits_left_q == 4'h1)
                        begin
                            tx_out_q <= 1'b1;
                            tx_state_q <= serial_pkg::TX_IDLE;
                        end
                        else
                        begin
                            tx_out_q <= shift_q[0];
                            shift_q <= {1'b1, shift_q[10:1]};
                        end
                    end
                end
                default:
                    tx_state_q <= serial_pkg::TX_IDLE;
            endcase
        end
    end
    assign tx_out = tx_out_q;

    // Checks
    sequence s_frame_over_full;
        rx_frame_done && !framing_error_flag && receive_full_flag_q;
    endsequence
    sequence s_frame_taken;
        rx_frame_done && !framing_error_flag && !receive_full_flag_q;
    endsequence

    a_overrun_sets: assert property (@(posedge core_clk) disable iff (!nrst)
        s_frame_over_full |=> err_q[serial_pkg::OVERRUN_BIT])
        else $error("overrun flag not set after frame over unread data");
    a_overrun_timing: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(err_q[serial_pkg::OVERRUN_BIT]) |-> $past(rx_frame_done))
        else $error("overrun rose without a completed frame");
    a_overrun_keeps_data: assert property (@(posedge core_clk) disable iff (!nrst)
        s_frame_over_full |=> $stable(rx_data_q))
        else $error("held character changed on overrun");
    a_clear_needs_arm: assert property (@(posedge core_clk) disable iff (!nrst)
        low_read && !armed_q[serial_pkg::OVERRUN_BIT] && err_q[serial_pkg::OVERRUN_BIT]
        |=> err_q[serial_pkg::OVERRUN_BIT])
        else $error("overrun cleared without prior status read");
    a_noise_with_full: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(err_q[serial_pkg::NOISE_BIT]) |-> $rose(receive_full_flag_q))
        else $error("noise flag rose apart from receive full");
    a_framing_sets: assert property (@(posedge core_clk) disable iff (!nrst)
        s_frame_taken ##0 !rx_frame.stop_bit |=> framing_error_flag && receive_full_flag_q)
        else $error("framing error not set on low stop bit");
    a_framing_blocks: assert property (@(posedge core_clk) disable iff (!nrst)
        framing_error_flag && rx_frame_done |=> $stable(rx_data_q)
        && !$rose(err_q[serial_pkg::OVERRUN_BIT]))
        else $error("frame taken while framing error stands");
    a_parity_sets: assert property (@(posedge core_clk) disable iff (!nrst)
        s_frame_taken ##0 parity_bad |=> err_q[serial_pkg::PARITY_ERR_BIT])
        else $error("parity error flag missed");
    a_armed_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        low_read && armed_q[serial_pkg::PARITY_ERR_BIT] && !err_set[serial_pkg::PARITY_ERR_BIT]
        |=> !err_q[serial_pkg::PARITY_ERR_BIT])
        else $error("armed parity flag survived low data read");
    a_tx_start_bit: assert property (@(posedge core_clk) disable iff (!nrst)
        tx_load |=> !tx_out ##1 !tx_out[*1])
        else $error("start bit not driven after load");
    a_write_buffers: assert property (@(posedge core_clk) disable iff (!nrst)
        low_write |=> fifo_out_valid)
        else $error("written character missing from the buffer");
    a_unarmed_survives: assert property (@(posedge core_clk) disable iff (!nrst)
        low_read && !armed_q[serial_pkg::NOISE_BIT] && err_q[serial_pkg::NOISE_BIT]
        |=> err_q[serial_pkg::NOISE_BIT])
        else $error("unarmed noise flag was cleared");
endmodule // serial_rx_errors_tx

/* File: testbench.sv */
// Self-checking testbench of the serial receive flags and transmit path
`timescale 1ns/1ps

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end

module testbench;
    localparam int BITC = 4;
    localparam logic [11:0] ST = serial_pkg::STATUS_ONE_ADDR;
    localparam logic [11:0] DH = serial_pkg::DATA_HIGH_ADDR;
    localparam logic [11:0] DL = serial_pkg::DATA_LOW_ADDR;
    localparam logic [11:0] CT = serial_pkg::CONTROL_ONE_ADDR;
    logic core_clk = 1'b0;
    logic nrst, psel, penable, pwrite, pready, pslverr, se;
    logic rx_frame_done, rx_accept_ok, tx_out, nine_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    serial_pkg::rx_frame_t rx_frame;
    int bad_count, total_checks, wt;

    // Clock at 125 MHz
    always #4 core_clk = ~core_clk;

    serial_rx_errors_tx #(.BIT_CYCLES(BITC), .FIFO_DEPTH(16)) u_dut (
        .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_frame_done(rx_frame_done),
        .rx_frame(rx_frame), .rx_accept_ok(rx_accept_ok), .tx_out(tx_out)
    );

    serial_node_model #(.BIT_CYCLES(BITC)) u_node (
        .core_clk(core_clk), .nrst(nrst), .tx_out(tx_out), .nine_mode(nine_mode),
        .rx_frame_done(rx_frame_done), .rx_frame(rx_frame)
    );

    // One APB transfer; held until pready is seen high, wait cycles left in wt
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic rdy;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge core_clk);
        penable <= 1'b1;
        wt = 0;
        rdy = 1'b0;
        // Answer read mid-cycle, so the edge that moves the registers cannot race it
        while (rdy !== 1'b1)
        begin
            @(negedge core_clk);
            rdy = (pready === 1'b1);
            rv = prdata;
            se = pslverr;
            @(posedge core_clk);
            if (rdy !== 1'b1)
                wt++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bounded wait for decoded frames
    task automatic wait_frames(input int n);
        int c;
        c = 0;
        while (u_node.got_q.size() < n && c < 5000)
        begin
            c++;
            @(posedge core_clk);
        end
    endtask

    task automatic t_reset();
        `CHK(tx_out, 1'b1)
        `CHK(rx_accept_ok, 1'b1)
        apb(1'b0, ST, 32'h0);
        `CHK({rv[5], rv[3:0]}, 5'h00)
        apb(1'b0, CT, 32'h0);
        `CHK(rv[7:0], serial_pkg::CONTROL_ONE_RESET)
        apb(1'b0, 12'h010, 32'h0);
        `CHK({se, rv}, {1'b1, 32'h0})
    endtask

    // Parity enable and type: even parity good and bad, odd parity bad, and parity disabled
    task automatic t_parity();
        logic [7:0] ctl[4] = '{8'h02, 8'h02, 8'h03, 8'h00};
        logic [8:0] dat[4] = '{9'h001, 9'h001, 9'h000, 9'h001};
        logic par[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
        logic ex[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, CT, {24'h0, ctl[i]});
            u_node.send(dat[i], 1'b0, 1'b1, par[i]);
            apb(1'b0, ST, 32'h0);
            `CHK({rv[5], rv[0]}, {1'b1, ex[i]})
            apb(1'b0, DL, 32'h0);
            `CHK(rv[7:0], dat[i][7:0])
            apb(1'b0, ST, 32'h0);
            `CHK({rv[5], rv[3:0]}, 5'h00)
        end
    endtask

    // Noise, then a framing error that must shut out the next frame
    task automatic t_flags();
        apb(1'b1, CT, 32'h0);
        u_node.send(9'h0c3, 1'b1, 1'b1, 1'b0);
        apb(1'b0, ST, 32'h0);
        `CHK({rv[5], rv[3:0]}, 5'h14)
        apb(1'b0, DL, 32'h0);
        apb(1'b0, ST, 32'h0);
        `CHK({rv[5], rv[3:0]}, 5'h00)
        u_node.send(9'h033, 1'b0, 1'b0, 1'b0);
        apb(1'b0, ST, 32'h0);
        `CHK({rv[5], rv[3:0]}, 5'h12)
        `CHK(rx_accept_ok, 1'b0)
        u_node.send(9'h044, 1'b1, 1'b1, 1'b0);
        apb(1'b0, ST, 32'h0);
        `CHK({rv[5], rv[3:0]}, 5'h12)
        apb(1'b0, DL, 32'h0);
        `CHK(rv[7:0], 8'h33)
        apb(1'b0, ST, 32'h0);
        `CHK({rv[5], rv[3:0]}, 5'h00)
        `CHK(rx_accept_ok, 1'b1)
    endtask

    // Overrun with the data read first, then a noise flag that survives a data read with no status read before it
    task automatic t_overrun();
        u_node.send(9'h011, 1'b0, 1'b1, 1'b0);
        u_node.send(9'h022, 1'b1, 1'b1, 1'b0);
        apb(1'b0, DL, 32'h0);
        `CHK(rv[7:0], 8'h11)
        apb(1'b0, ST, 32'h0);
        `CHK({rv[5], rv[3:0]}, 5'h08)
        apb(1'b0, DL, 32'h0);
        apb(1'b0, ST, 32'h0);
        `CHK({rv[5], rv[3:0]}, 5'h00)
        u_node.send(9'h055, 1'b1, 1'b1, 1'b0);
        apb(1'b0, DL, 32'h0);
        `CHK(rv[7:0], 8'h55)
        apb(1'b0, ST, 32'h0);
        `CHK({rv[5], rv[3:0]}, 5'h04)
        apb(1'b0, DL, 32'h0);
        apb(1'b0, ST, 32'h0);
        `CHK({rv[5], rv[3:0]}, 5'h00)
    endtask

    // Nine-bit characters; the buffers do not read back what was written
    task automatic t_tx9();
        nine_mode <= 1'b1;
        apb(1'b1, CT, 32'h14);
        apb(1'b1, DH, 32'h40);
        apb(1'b1, DL, 32'h5a);
        apb(1'b1, DH, 32'h00);
        apb(1'b1, DL, 32'ha5);
        u_node.send(9'h1a5, 1'b0, 1'b1, 1'b0);
        apb(1'b0, DH, 32'h0);
        `CHK(rv[6], 1'b0)
        `CHK(rv[7], 1'b1)
        apb(1'b0, DL, 32'h0);
        `CHK(rv[7:0], 8'ha5)
        wait_frames(2);
        `CHK(u_node.got_q[0], 10'h35a)
        `CHK(u_node.got_q[1], 10'h2a5)
        u_node.got_q.delete();
    endtask

    // Fill the buffer while disabled, overfill once enabled, drain to idle
    task automatic t_fill();
        nine_mode <= 1'b0;
        apb(1'b1, CT, 32'h00);
        apb(1'b1, DH, 32'h00);
        for (int i = 0; i < 16; i++)
            apb(1'b1, DL, 32'h10 + i);
        `CHK(tx_out, 1'b1)
        apb(1'b1, CT, 32'h04);
        apb(1'b1, DL, 32'h20);
        apb(1'b1, DL, 32'h21);
        `CHK(wt > 20, 1'b1)
        wait_frames(18);
        for (int i = 0; i < 18; i++)
            `CHK(u_node.got_q[i], {2'b10, 8'(8'h10 + i)})
        repeat (4 * BITC) @(posedge core_clk);
        apb(1'b0, ST, 32'h0);
        `CHK(rv[7], 1'b1)
    endtask

    // Single place where the run ends
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        nine_mode = 1'b0;
        bad_count = 0;
        total_checks = 0;
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_parity();
        t_flags();
        t_overrun();
        t_tx9();
        t_fill();
        report_and_stop();
    end

    // Watchdog, well beyond the thousand or so cycles the tests need
    initial
    begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule // testbench
